// [rtl/tpw_top.sv]
// three-phase center-based pwm controller with apb registers
//
// Chosen here: the APB register port and the placing of the registers.
module tpw_top
   import tpw_pkg::*;
#(
   parameter int PHASES = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [TPW_AW-1:0] paddr,
   input wire logic [TPW_DW-1:0] pwdata,
   output logic [TPW_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trip_input_n,
   input wire logic [PHASES-1:0] sense_high,
   input wire logic [PHASES-1:0] sense_low,
   input wire logic [PHASES-1:0] sense_float,
   output logic phase_a_high,
   output logic phase_a_low,
   output logic phase_b_high,
   output logic phase_b_low,
   output logic phase_c_high,
   output logic phase_c_low,
   output logic converter_sync_pulse,
   output logic sync_irq,
   output logic trip_irq
);

   // on/off of one pair for the current count, index 1 = high, 0 = low
   function automatic logic [1:0] tpw_wave(
      input logic [15:0] cnt,
      input logic [15:0] per,
      input logic [15:0] duty,
      input logic [9:0] dt,
      input logic [9:0] pd
   );
      logic [16:0] t;
      logic [16:0] hi_t;
      logic [16:0] hon;
      logic hi;
      logic lo;
      t = 17'h0_0000;
      if (duty < per) begin
         t = {1'b0, per} - {1'b0, duty};
      end
      hi_t = t + {6'h00, dt, 1'b0};
      hi = {1'b0, cnt} >= hi_t;
      lo = {1'b0, cnt} < t;
      hon = 17'h0_0000;
      if (hi_t < {1'b0, per}) begin
         hon = {1'b0, per} - hi_t;
      end
      // pulses narrower than the deletion width are dropped entirely
      if (hon < {7'h00, pd}) begin
         hi = 1'b0;
      end
      if (t < {7'h00, pd}) begin
         lo = 1'b0;
      end
      return {hi, lo};
   endfunction : tpw_wave

   function automatic logic tpw_mapped(input logic [11:0] a);
      logic ok;
      ok = 1'b0;
      case (a)
         TPW_OFS_PERIOD, TPW_OFS_DEAD, TPW_OFS_PDEL,
         TPW_OFS_DUTY_A, TPW_OFS_DUTY_B, TPW_OFS_DUTY_C,
         TPW_OFS_SEG, TPW_OFS_GATE, TPW_OFS_MODE,
         TPW_OFS_SYNCW, TPW_OFS_SWTRIP, TPW_OFS_STATUS,
         TPW_OFS_RESTART: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : tpw_mapped

   // software-visible registers
   logic [15:0] period_register;
   logic [9:0] dead_time_register;
   logic [9:0] pulse_deletion_register;
   logic [15:0] duty_phase_a;
   logic [15:0] duty_phase_b;
   logic [15:0] duty_phase_c;
   logic [8:0] output_segment_register;
   logic [9:0] gate_drive_control;
   logic [7:0] mode_control_register;
   logic [7:0] sync_width_register;

   // copies latched into the timing unit at update points
   logic [15:0] per_l;
   logic [9:0] dt_l;
   logic [9:0] pd_l;
   logic [15:0] duty_l [PHASES];
   logic [8:0] seg_l;

   logic [15:0] cnt;
   tpw_dir_t dir;
   logic [7:0] sync_left;
   logic [7:0] chop_cnt;
   logic chop;
   logic shut;
   logic next_shut;
   logic [31:0] status;

   logic wr;
   logic rd_setup;
   logic sw_trip;
   logic restart;
   logic analog_trip;
   logic hw_trip;
   logic run;
   logic start_ev;
   logic mid_ev;
   logic upd;
   logic double_mode;

   assign wr = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign sw_trip = wr & (paddr == TPW_OFS_SWTRIP);
   assign restart = wr & (paddr == TPW_OFS_RESTART);
   assign analog_trip = |(sense_high | sense_low | sense_float);
   assign hw_trip = ~trip_input_n | analog_trip;
   assign run = ~shut;
   assign double_mode = mode_control_register[TPW_MODE_DOUBLE_BIT];

   // zero wait states; only an unmapped address is answered with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~tpw_mapped(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_register <= TPW_PERIOD_RST;
         dead_time_register <= TPW_DEAD_RST;
         pulse_deletion_register <= TPW_PDEL_RST;
         duty_phase_a <= TPW_DUTY_RST;
         duty_phase_b <= TPW_DUTY_RST;
         duty_phase_c <= TPW_DUTY_RST;
         output_segment_register <= TPW_SEG_RST;
         gate_drive_control <= TPW_GATE_RST;
         mode_control_register <= TPW_MODE_RST;
         sync_width_register <= TPW_SYNCW_RST;
      end else if (wr) begin
         case (paddr)
            TPW_OFS_PERIOD: period_register <= pwdata[15:0];
            TPW_OFS_DEAD: dead_time_register <= pwdata[9:0];
            TPW_OFS_PDEL: pulse_deletion_register <= pwdata[9:0];
            TPW_OFS_DUTY_A: duty_phase_a <= pwdata[15:0];
            TPW_OFS_DUTY_B: duty_phase_b <= pwdata[15:0];
            TPW_OFS_DUTY_C: duty_phase_c <= pwdata[15:0];
            TPW_OFS_SEG: output_segment_register <= pwdata[8:0];
            TPW_OFS_GATE: gate_drive_control <= pwdata[9:0];
            TPW_OFS_MODE: mode_control_register <= pwdata[7:0];
            TPW_OFS_SYNCW: sync_width_register <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      status = 32'h0000_0000;
      status[TPW_STAT_TRIP_BIT] = trip_input_n;
      status[TPW_STAT_SHUT_BIT] = shut;
      status[TPW_STAT_ANALOG_BIT] = analog_trip;
      status[TPW_STAT_HALF_BIT] = (dir == TPW_CNT_DOWN);
   end

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr)
            TPW_OFS_PERIOD: prdata <= {16'h0000, period_register};
            TPW_OFS_DEAD: prdata <= {22'h00_0000, dead_time_register};
            TPW_OFS_PDEL: prdata <= {22'h00_0000, pulse_deletion_register};
            TPW_OFS_DUTY_A: prdata <= {16'h0000, duty_phase_a};
            TPW_OFS_DUTY_B: prdata <= {16'h0000, duty_phase_b};
            TPW_OFS_DUTY_C: prdata <= {16'h0000, duty_phase_c};
            TPW_OFS_SEG: prdata <= {23'h00_0000, output_segment_register};
            TPW_OFS_GATE: prdata <= {22'h00_0000, gate_drive_control};
            TPW_OFS_MODE: prdata <= {24'h00_0000, mode_control_register};
            TPW_OFS_SYNCW: prdata <= {24'h00_0000, sync_width_register};
            TPW_OFS_STATUS: prdata <= status;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // shutdown latch: a new trip in the restart cycle keeps it set
   always_comb begin
      next_shut = shut;
      if (restart && !hw_trip) begin
         next_shut = 1'b0;
      end
      if (hw_trip || sw_trip) begin
         next_shut = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shut <= 1'b0;
         trip_irq <= 1'b0;
      end else begin
         shut <= next_shut;
         trip_irq <= next_shut & ~shut;
      end
   end

   // counter runs 0..P-1 upward then P..1 downward: 2P cycles per period
   assign start_ev = run & (dir == TPW_CNT_UP) & (cnt == 16'h0000);
   assign mid_ev = run & (dir == TPW_CNT_DOWN) & (cnt == per_l);
   assign upd = start_ev | (mid_ev & double_mode);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 16'h0000;
         dir <= TPW_CNT_UP;
      end else if (!run) begin
         cnt <= 16'h0000;
         dir <= TPW_CNT_UP;
      end else begin
         case (dir)
            TPW_CNT_UP: begin
               if (cnt >= per_l - 16'h0001) begin
                  dir <= TPW_CNT_DOWN;
                  cnt <= per_l;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            TPW_CNT_DOWN: begin
               if (cnt <= 16'h0001) begin
                  dir <= TPW_CNT_UP;
                  cnt <= 16'h0000;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            default: begin
               dir <= TPW_CNT_UP;
               cnt <= 16'h0000;
            end
         endcase
      end
   end

   // a zero period would stall the counter, so it is latched as one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_l <= 16'h0001;
         dt_l <= TPW_DEAD_RST;
         pd_l <= TPW_PDEL_RST;
         seg_l <= TPW_SEG_RST;
         for (int i = 0; i < PHASES; i++) begin
            duty_l[i] <= TPW_DUTY_RST;
         end
      end else if (upd) begin
         per_l <= (period_register == 16'h0000) ? 16'h0001 :
                  period_register;
         dt_l <= dead_time_register;
         pd_l <= pulse_deletion_register;
         seg_l <= output_segment_register;
         duty_l[0] <= duty_phase_c;
         duty_l[1] <= duty_phase_b;
         duty_l[2] <= duty_phase_a;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_sync_pulse <= 1'b0;
         sync_left <= 8'h00;
         sync_irq <= 1'b0;
      end else begin
         sync_irq <= upd;
         if (upd) begin
            converter_sync_pulse <= 1'b1;
            // taken at the update edge, so no separate latched copy is kept
            sync_left <= sync_width_register;
         end else if (sync_left != 8'h00) begin
            sync_left <= sync_left - 8'h01;
         end else begin
            converter_sync_pulse <= 1'b0;
         end
      end
   end

   // chop toggles every value+1 cycles, period 2*(value+1) cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chop_cnt <= 8'h00;
         chop <= 1'b0;
      end else if (chop_cnt >= gate_drive_control[7:0]) begin
         chop_cnt <= 8'h00;
         chop <= ~chop;
      end else begin
         chop_cnt <= chop_cnt + 8'h01;
      end
   end

   // output control, gate drive mixing and unclocked shutdown gating
   logic [PHASES-1:0] out_hi;
   logic [PHASES-1:0] out_lo;

   always_comb begin
      logic [1:0] w;
      logic h;
      logic l;
      w = 2'b00;
      h = 1'b0;
      l = 1'b0;
      out_hi = '0;
      out_lo = '0;
      for (int i = 0; i < PHASES; i++) begin
         w = tpw_wave(cnt, per_l, duty_l[i], dt_l, pd_l);
         if (seg_l[TPW_SEG_XOVER_LSB + i]) begin
            h = w[0];
            l = w[1];
         end else begin
            h = w[1];
            l = w[0];
         end
         h = h & ~seg_l[2*i+1];
         l = l & ~seg_l[2*i];
         if (gate_drive_control[TPW_GATE_HI_EN_BIT]) begin
            h = h & chop;
         end
         if (gate_drive_control[TPW_GATE_LO_EN_BIT]) begin
            l = l & chop;
         end
         // pin and sense terms act without any clock edge
         out_hi[i] = h & run & ~hw_trip;
         out_lo[i] = l & run & ~hw_trip;
      end
   end

   assign phase_a_high = out_hi[2];
   assign phase_a_low = out_lo[2];
   assign phase_b_high = out_hi[1];
   assign phase_b_low = out_lo[1];
   assign phase_c_high = out_hi[0];
   assign phase_c_low = out_lo[0];

   // every register above runs on pclk, the instruction clock
endmodule : tpw_top

// [pkg/tpw_pkg.sv]
// constants and types shared by the three-phase pwm controller
package tpw_pkg;
   localparam int TPW_AW = 12;
   localparam int TPW_DW = 32;
   localparam int TPW_PER_W = 16;
   localparam int TPW_DT_W = 10;
   localparam int TPW_PD_W = 10;
   localparam int TPW_SW_W = 8;
   localparam int TPW_SEG_W = 9;
   localparam int TPW_GATE_W = 10;
   localparam int TPW_MODE_W = 8;

   localparam logic [11:0] TPW_OFS_PERIOD = 12'h000;
   localparam logic [11:0] TPW_OFS_DEAD = 12'h004;
   localparam logic [11:0] TPW_OFS_PDEL = 12'h008;
   localparam logic [11:0] TPW_OFS_DUTY_A = 12'h00C;
   localparam logic [11:0] TPW_OFS_DUTY_B = 12'h010;
   localparam logic [11:0] TPW_OFS_DUTY_C = 12'h014;
   localparam logic [11:0] TPW_OFS_SEG = 12'h018;
   localparam logic [11:0] TPW_OFS_GATE = 12'h01C;
   localparam logic [11:0] TPW_OFS_MODE = 12'h020;
   localparam logic [11:0] TPW_OFS_SYNCW = 12'h024;
   localparam logic [11:0] TPW_OFS_SWTRIP = 12'h028;
   localparam logic [11:0] TPW_OFS_STATUS = 12'h02C;
   localparam logic [11:0] TPW_OFS_RESTART = 12'h030;

   localparam logic [15:0] TPW_PERIOD_RST = 16'h0000;
   localparam logic [9:0] TPW_DEAD_RST = 10'h000;
   localparam logic [9:0] TPW_PDEL_RST = 10'h000;
   localparam logic [15:0] TPW_DUTY_RST = 16'h0000;
   localparam logic [8:0] TPW_SEG_RST = 9'h000;
   localparam logic [9:0] TPW_GATE_RST = 10'h000;
   localparam logic [7:0] TPW_MODE_RST = 8'h00;
   localparam logic [7:0] TPW_SYNCW_RST = 8'h27;

   localparam int TPW_MODE_DOUBLE_BIT = 6;
   localparam int TPW_GATE_HI_EN_BIT = 8;
   localparam int TPW_GATE_LO_EN_BIT = 9;
   localparam int TPW_SEG_XOVER_LSB = 6;
   localparam int TPW_STAT_TRIP_BIT = 0;
   localparam int TPW_STAT_SHUT_BIT = 1;
   localparam int TPW_STAT_ANALOG_BIT = 2;
   localparam int TPW_STAT_HALF_BIT = 3;

   typedef enum logic {TPW_CNT_UP, TPW_CNT_DOWN} tpw_dir_t;
endpackage : tpw_pkg

// [testbench/tpw_sva.sv]
// port-level assertions for the three-phase pwm controller
module tpw_sva
   import tpw_pkg::*;
#(
   parameter int PHASES = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic trip_input_n,
   input wire logic [PHASES-1:0] sense_high,
   input wire logic [PHASES-1:0] sense_low,
   input wire logic [PHASES-1:0] sense_float,
   input wire logic phase_a_high,
   input wire logic phase_a_low,
   input wire logic phase_b_high,
   input wire logic phase_b_low,
   input wire logic phase_c_high,
   input wire logic phase_c_low,
   input wire logic converter_sync_pulse,
   input wire logic sync_irq,
   input wire logic trip_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] drv;
   assign drv = {phase_a_high, phase_a_low, phase_b_high, phase_b_low,
      phase_c_high, phase_c_low};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // three cycles of trip give the shutdown latch time to stop the counter
   sequence s_tripped;
      !trip_input_n [*3];
   endsequence
   sequence s_sync_start;
      $rose(converter_sync_pulse);
   endsequence
   property p_trip_off;
      !trip_input_n |-> drv == 6'h00;
   endproperty
   property p_sense_off;
      |{sense_high, sense_low, sense_float} |-> drv == 6'h00;
   endproperty
   property p_no_overlap;
      !(drv[5] && drv[4]) && !(drv[3] && drv[2]) && !(drv[1] && drv[0]);
   endproperty
   property p_stopped;
      s_tripped |-> !sync_irq;
   endproperty
   property p_sync_irq;
      sync_irq |-> converter_sync_pulse;
   endproperty
   property p_sync_rise;
      s_sync_start |-> sync_irq;
   endproperty
   property p_trip_irq;
      trip_irq |=> !trip_irq;
   endproperty
   property p_pready;
      psel && penable |-> pready;
   endproperty
   a_trip_off: assert property (p_trip_off)
      else $error("gate drive on while trip pin low");
   a_sense_off: assert property (p_sense_off)
      else $error("gate drive on during sense fault");
   a_no_overlap: assert property (p_no_overlap)
      else $error("both sides of one leg on");
   a_stopped: assert property (p_stopped)
      else $error("sync while shut down");
   a_sync_irq: assert property (p_sync_irq)
      else $error("sync interrupt without sync pulse");
   a_sync_rise: assert property (p_sync_rise)
      else $error("sync pulse rose without interrupt");
   a_trip_irq: assert property (p_trip_irq)
      else $error("trip interrupt longer than one cycle");
   a_pready: assert property (p_pready)
      else $error("no ready in access phase");
endmodule : tpw_sva

// [testbench/tpw_gate_model.sv]
// gate driver and current-sense comparator model on the inverter side
module tpw_gate_model (
   input wire logic [5:0] gates,
   input wire logic [1:0] fault_sel,
   output logic [2:0] sense_high,
   output logic [2:0] sense_low,
   output logic [2:0] sense_float,
   output logic shoot
);
   timeunit 1ns;
   timeprecision 1ps;
   // a leg with both switches on shorts the dc link
   assign shoot = |(gates[5:0] & {gates[4:0], 1'b0} & 6'h2A);
   // over on phase a, under on phase b, open input on phase c
   assign sense_high = (fault_sel == 2'h1) ? 3'h4 : 3'h0;
   assign sense_low = (fault_sel == 2'h2) ? 3'h2 : 3'h0;
   assign sense_float = (fault_sel == 2'h3) ? 3'h1 : 3'h0;
endmodule : tpw_gate_model

// [testbench/tpw_top_tb.sv]
// self-checking bench for the three-phase pwm controller
module tpw_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tpw_pkg::*;
   localparam int P = 16;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [TPW_AW-1:0] paddr;
   logic [TPW_DW-1:0] pwdata, prdata, rd;
   logic trip_input_n, converter_sync_pulse, sync_irq, trip_irq, shoot;
   logic phase_a_high, phase_a_low, phase_b_high, phase_b_low;
   logic phase_c_high, phase_c_low;
   logic [2:0] sense_high, sense_low, sense_float;
   logic [1:0] fault_sel;
   logic [6:0] mon;
   int fails, check_count, gap;
   int hi [7];
   int rs [7];
   assign mon = {converter_sync_pulse, phase_a_high, phase_a_low,
      phase_b_high, phase_b_low, phase_c_high, phase_c_low};
   tpw_top #(.PHASES(3)) i_tpw_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trip_input_n(trip_input_n),
      .sense_high(sense_high), .sense_low(sense_low),
      .sense_float(sense_float), .phase_a_high(phase_a_high),
      .phase_a_low(phase_a_low), .phase_b_high(phase_b_high),
      .phase_b_low(phase_b_low), .phase_c_high(phase_c_high),
      .phase_c_low(phase_c_low), .sync_irq(sync_irq),
      .converter_sync_pulse(converter_sync_pulse), .trip_irq(trip_irq));
   tpw_gate_model i_tpw_gate_model (.gates(mon[5:0]),
      .fault_sel(fault_sel), .sense_high(sense_high),
      .sense_low(sense_low), .sense_float(sense_float), .shoot(shoot));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      if (fails == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // gap ends up as the cycle distance from the previous sync interrupt
   task automatic wait_sync;
      gap = 0;
      do begin
         @(negedge pclk);
         gap++;
      end while (sync_irq !== 1'b1 && gap < 2000);
      if (sync_irq !== 1'b1) begin
         fails++;
         wrap_up();
      end
   endtask : wait_sync
   // outputs are sampled on the falling edge, where they have settled
   task automatic measure(input int n);
      logic [6:0] prev;
      prev = mon;
      hi = '{default: 0};
      rs = '{default: 0};
      repeat (n) begin
         @(negedge pclk);
         for (int i = 0; i < 7; i++) begin
            hi[i] += int'(mon[i]);
            rs[i] += int'(mon[i] & ~prev[i]);
         end
         check(shoot, 1'b0);
         prev = mon;
      end
   endtask : measure
   task automatic t_regs;
      apb(1'b0, TPW_OFS_SYNCW, '0);
      check(rd, 32'h0000_0027);
      apb(1'b0, TPW_OFS_STATUS, '0);
      check(rd[TPW_STAT_TRIP_BIT], 1'b1);
      apb(1'b0, 12'h0FC, '0);
      check(err, 1'b1);
   endtask : t_regs
   task automatic t_sync;
      logic half;
      apb(1'b1, TPW_OFS_PERIOD, P);
      apb(1'b1, TPW_OFS_SYNCW, 32'h0000_0002);
      wait_sync;
      wait_sync;
      check(gap, 2 * P);
      measure(2 * P);
      check(hi[6], 3);
      apb(1'b1, TPW_OFS_MODE, 32'h0000_0040);
      wait_sync;
      wait_sync;
      check(gap, P);
      apb(1'b0, TPW_OFS_STATUS, '0);
      half = rd[TPW_STAT_HALF_BIT];
      wait_sync;
      apb(1'b0, TPW_OFS_STATUS, '0);
      check(half ^ rd[TPW_STAT_HALF_BIT], 1'b1);
      apb(1'b1, TPW_OFS_MODE, '0);
   endtask : t_sync
   task automatic t_duty;
      apb(1'b1, TPW_OFS_DUTY_A, 32'h0000_0004);
      apb(1'b1, TPW_OFS_DUTY_B, 32'h0000_0005);
      apb(1'b1, TPW_OFS_DUTY_C, 32'h0000_0006);
      wait_sync;
      measure(2 * P);
      for (int k = 0; k < 3; k++) begin
         check(hi[2 * k + 1] + hi[2 * k], 2 * P);
      end
      check(hi[3] - hi[5], 2);
      check(hi[1] - hi[3], 2);
      apb(1'b1, TPW_OFS_DEAD, 32'h0000_0001);
      wait_sync;
      measure(2 * P);
      for (int k = 0; k < 3; k++) begin
         check(hi[2 * k + 1] + hi[2 * k], 2 * P - 4);
      end
      apb(1'b1, TPW_OFS_DEAD, '0);
      apb(1'b1, TPW_OFS_PDEL, 32'h0000_0005);
      wait_sync;
      measure(2 * P);
      check(hi[5], 0);
      check(hi[3] > 0, 1'b1);
      apb(1'b1, TPW_OFS_PDEL, '0);
   endtask : t_duty
   task automatic t_seg;
      int a_hi;
      wait_sync;
      measure(2 * P);
      a_hi = hi[5];
      apb(1'b1, TPW_OFS_SEG, 32'h0000_0120);
      wait_sync;
      measure(2 * P);
      check(hi[5], 0);
      check(hi[4], a_hi);
      apb(1'b1, TPW_OFS_SEG, '0);
   endtask : t_seg
   task automatic t_chop;
      int fast;
      apb(1'b1, TPW_OFS_GATE, 32'h0000_0100);
      wait_sync;
      measure(2 * P);
      fast = rs[1];
      check(fast > 1, 1'b1);
      check(rs[0], 1);
      apb(1'b1, TPW_OFS_GATE, 32'h0000_0103);
      wait_sync;
      measure(2 * P);
      check(rs[1] < fast, 1'b1);
      apb(1'b1, TPW_OFS_GATE, 32'h0000_0200);
      wait_sync;
      measure(2 * P);
      check(rs[1], 1);
      check(rs[0] > 1, 1'b1);
      apb(1'b1, TPW_OFS_GATE, '0);
   endtask : t_chop
   // src 0 pin, 1 software, 2..4 sense over, under, open
   task automatic t_shut(input int src);
      int n;
      if (src == 1) begin
         apb(1'b1, TPW_OFS_SWTRIP, 32'h0000_0001);
      end else begin
         @(posedge pclk);
         trip_input_n <= (src != 0);
         fault_sel <= (src > 1) ? 2'(src - 1) : 2'h0;
      end
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (trip_irq !== 1'b1 && n < 4);
      check(trip_irq, 1'b1);
      check(mon[5:0], 6'h00);
      apb(1'b0, TPW_OFS_STATUS, '0);
      check(rd[TPW_STAT_TRIP_BIT], src != 0);
      trip_input_n <= 1'b1;
      fault_sel <= 2'h0;
      measure(2 * P);
      check(hi.sum(), 0);
      apb(1'b1, TPW_OFS_RESTART, 32'h0000_0001);
      wait_sync;
      measure(2 * P);
      check(hi[4] > 0, 1'b1);
   endtask : t_shut
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      trip_input_n = 1'b1;
      fault_sel = 2'h0;
      fails = 0;
      check_count = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_sync();
      t_duty();
      t_seg();
      t_chop();
      for (int s = 0; s < 5; s++) begin
         t_shut(s);
      end
      wrap_up();
   end
endmodule : tpw_top_tb
bind tpw_top tpw_sva #(.PHASES(PHASES)) i_tpw_sva (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .trip_input_n(trip_input_n), .sense_high(sense_high),
   .sense_low(sense_low), .sense_float(sense_float),
   .phase_a_high(phase_a_high), .phase_a_low(phase_a_low),
   .phase_b_high(phase_b_high), .phase_b_low(phase_b_low),
   .phase_c_high(phase_c_high), .phase_c_low(phase_c_low),
   .converter_sync_pulse(converter_sync_pulse), .sync_irq(sync_irq),
   .trip_irq(trip_irq));
